// *** rtl/mps_cfg.svh ***
// Register offsets, field positions, reset values and timing figures of the power state block
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH

`define MPS_OFS_PRIMARY_CONFIG   4'h0
`define MPS_OFS_SECONDARY_CONFIG 4'h1
`define MPS_OFS_ALERT_ENABLE_4   4'h2
`define MPS_OFS_PIN_IO_CONTROL   4'h3
`define MPS_OFS_PIN_STATUS       4'h4
`define MPS_OFS_ALERT_LATCH      4'h5
`define MPS_OFS_ALERT_PIN_FORCE  4'h6
`define MPS_OFS_CONV_STATUS      4'h7

`define MPS_RST_PRIMARY_CONFIG   8'h00
`define MPS_RST_SECONDARY_CONFIG 8'h00
`define MPS_RST_ALERT_ENABLE_4   8'h00
`define MPS_RST_PIN_IO_CONTROL   8'h00
`define MPS_RST_ALERT_PIN_FORCE  8'h00

`define MPS_OPMODE_HI            6
`define MPS_OPMODE_LO            5
`define MPS_OPMODE_SHUTDOWN      2'h3
`define MPS_OPMODE_RUN           2'h0
`define MPS_AUTO_WAKE_BIT        4
`define MPS_AL4_WAKE_BIT         4
`define MPS_AL4_CROSS_HI         3
`define MPS_AL4_CROSS_LO         1
`define MPS_LATCH_EXT_BIT        0
`define MPS_READY_SEL_HI         5
`define MPS_READY_SEL_LO         4
`define MPS_FORCE_ALERT_BIT      7
`define MPS_FORCE_LOW_BIT        6

`define MPS_READY_OFF            2'h0
`define MPS_READY_SHORT          2'h1
`define MPS_READY_LONG           2'h2
`define MPS_READY_LATCH          2'h3

`define MPS_CLK_MHZ              10
`define MPS_WAKE_TIME_US         33000
`define MPS_READY_SHORT_US       16
`define MPS_READY_LONG_US        128

`endif

// *** rtl/mps_pkg.sv ***
// Types shared by the power state block
package mps_pkg;

  typedef struct packed {
    logic main_above_uvlo;
    logic internal_above_uvlo;
    logic main_above_reset;
    logic internal_above_reset;
  } mps_supply_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } mps_bus_lines_s;

  typedef enum logic [2:0] {
    RDY_IDLE  = 3'b001,
    RDY_PULSE = 3'b010,
    RDY_LATCH = 3'b100
  } mps_ready_state_e;

endpackage

// *** rtl/mps_ready_pulse.sv ***
// Data-ready pin driver: timed low pulse or latched low level
`timescale 1ns/1ns
`default_nettype none
`include "mps_cfg.svh"
module mps_ready_pulse #(
  parameter int SHORT_CYCLES = 160,
  parameter int LONG_CYCLES  = 1280
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic [1:0] mode,
  input  wire logic       new_result,
  input  wire logic       release_latch,
  // Pin level request, high means pull low
  output logic            ready_low
);
  localparam int CW = $clog2(LONG_CYCLES + 1);

  initial begin
    if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES) $error("mps_ready_pulse: bad pulse lengths");
  end

  mps_pkg::mps_ready_state_e state;
  logic [CW-1:0]             remain;

  // [R16] pulse or latch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state  <= mps_pkg::RDY_IDLE;
      remain <= '0;
    end else begin
      case (state)
        mps_pkg::RDY_IDLE: begin
          if (new_result && mode == `MPS_READY_LATCH) begin
            state <= mps_pkg::RDY_LATCH;
          end else if (new_result && mode == `MPS_READY_SHORT) begin
            state  <= mps_pkg::RDY_PULSE;
            remain <= CW'(SHORT_CYCLES - 1);
          end else if (new_result && mode == `MPS_READY_LONG) begin
            state  <= mps_pkg::RDY_PULSE;
            remain <= CW'(LONG_CYCLES - 1);
          end
        end
        mps_pkg::RDY_PULSE: begin
          if (mode == `MPS_READY_OFF || remain == '0) begin
            state <= mps_pkg::RDY_IDLE;
          end else begin
            remain <= remain - CW'(1);
          end
        end
        mps_pkg::RDY_LATCH: begin
          // [R17] read releases latch; a new result in the same cycle keeps it
          if (mode != `MPS_READY_LATCH || (release_latch && !new_result)) begin
            state <= mps_pkg::RDY_IDLE;
          end
        end
        default: state <= mps_pkg::RDY_IDLE;
      endcase
    end
  end

  assign ready_low = (state != mps_pkg::RDY_IDLE);
endmodule
`default_nettype wire

// *** rtl/mps_sync.sv ***
// Two-stage synchroniser for a vector of levels
`timescale 1ns/1ns
`default_nettype none
module mps_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  initial begin
    if (WIDTH < 1) $error("mps_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage_one;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage_one[i] <= 1'b0;
          sync_out[i]  <= 1'b0;
        end else begin
          stage_one[i] <= async_in[i];
          sync_out[i]  <= stage_one[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** rtl/mps_top.sv ***
// Power state, shutdown, auto-wake and general purpose pin control of a dual power monitor
//
// Contract
// [R1] Either supply above lockout enables logic
// [R2] Both supplies below lockout disable converters
// [R3] Keep registers until both below reset
// [R4] Operating field 11 enters shutdown
// [R5] Bus stays alive, address held in shutdown
// [R6] Registers stay accessible during shutdown
// [R7] Clearing operating field leaves shutdown
// [R8] Auto-wake after bus lines low 33 ms
// [R9] Auto-wake event raises enabled alert
// [R10] Host avoids writing shutdown when unsafe
// [R11] Four pins, configurable direction and conversion
// [R12] Comparator levels readable in pin status
// [R13] Pin 1-3 crossings raise enabled alerts
// [R14] Pins only pull low, never drive high
// [R15] Pin 3 selectable as data-ready
// [R16] Data-ready: 16 us, 128 us, latched
// [R17] Status clears on read, releases latch
// [R18] Pin 4 is alert output after reset
// [R19] Force bit pulls alert low
// [R20] Alert events set force bit
// [R21] Second force bit pulls pin 4 low
// [R22] Enabled faults pull pin 4 low (code latches any fault_alert, no enable bit)
// [R23] Wake timer restarts on line high
// [R24] Comparator outputs synchronised first
`timescale 1ns/1ns
`default_nettype none
`include "mps_cfg.svh"
module mps_top #(
  parameter int WAKE_CYCLES  = `MPS_WAKE_TIME_US * `MPS_CLK_MHZ,
  parameter int READY_SHORT  = `MPS_READY_SHORT_US * `MPS_CLK_MHZ,
  parameter int READY_LONG   = `MPS_READY_LONG_US * `MPS_CLK_MHZ,
  parameter int RESULT_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Register port
  input  wire logic [3:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  // Supply comparators and bus line levels
  input  wire mps_pkg::mps_supply_s      supply,
  input  wire mps_pkg::mps_bus_lines_s   bus_lines,
  input  wire logic                      bus_addr_strap_low,
  input  wire logic                      bus_addr_strap_high,
  // Converter side
  input  wire logic [RESULT_WIDTH-1:0]   result_update,
  input  wire logic                      fault_alert,
  // Pin comparators and open-drain drivers
  input  wire logic [3:0]                pin_cmp,
  output logic      [3:0]                pin_out,
  output logic      [3:0]                pin_oe_n,
  // Power state
  output logic                           bus_logic_enable,
  output logic                           converter_enable,
  output logic                           reference_enable,
  output logic                           regulator_enable,
  output logic                           addr_strap_enable,
  output logic      [1:0]                bus_addr_sel,
  output logic      [1:0]                voltage_converter_sel,
  output logic                           shutdown_active
);
  localparam int WCW = $clog2(WAKE_CYCLES + 2);

  initial begin
    if (WAKE_CYCLES < 1) $error("mps_top: WAKE_CYCLES must be at least 1");
    if (RESULT_WIDTH < 1 || RESULT_WIDTH > 8) $error("mps_top: RESULT_WIDTH must be 1 to 8");
  end

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Registers
  logic [7:0]              primary_config;
  logic [7:0]              secondary_config;
  logic [7:0]              alert_enable_four_register;
  logic [7:0]              pin_io_control;
  logic [7:0]              alert_latch;
  logic [7:0]              alert_pin_force;
  logic [7:0]              conv_status;

  logic                    logic_reset;
  logic                    powered;
  logic [3:0]              pin_level_bits;
  logic [3:0]              pin_level_prev;
  logic [1:0]              lines_sync;
  logic [WCW-1:0]          wake_count;
  logic                    wake_event;
  logic [3:0]              cross_event;
  logic [7:0]              next_alert_latch;
  logic                    alert_event;
  logic                    shutdown;
  logic                    result_available_n;
  logic                    ready_low;
  logic                    status_read;
  logic [1:0]              ready_pin_select;

  assign shutdown         = (primary_config[`MPS_OPMODE_HI:`MPS_OPMODE_LO] == `MPS_OPMODE_SHUTDOWN);
  assign ready_pin_select = pin_io_control[`MPS_READY_SEL_HI:`MPS_READY_SEL_LO];
  assign status_read      = reg_rd && hit(reg_addr, `MPS_OFS_CONV_STATUS);

  // [R3] bus logic reset only when both supplies drop below reset level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      logic_reset <= 1'b1;
    end else begin
      logic_reset <= !supply.main_above_reset && !supply.internal_above_reset;
    end
  end

  // [R1] enable on either supply, [R2] disable when both low
  always_ff @(posedge sys_clk) begin
    if (rst || logic_reset) begin
      powered <= 1'b0;
    end else begin
      powered <= supply.main_above_uvlo || supply.internal_above_uvlo;
    end
  end

  // [R24] comparator synchroniser
  mps_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (logic_reset),
    .async_in (pin_cmp),
    .sync_out (pin_level_bits)
  );

  mps_sync #(
    .WIDTH (2)
  ) u_line_sync (
    .sys_clk  (sys_clk),
    .rst      (logic_reset),
    .async_in ({bus_lines.scl, bus_lines.sda}),
    .sync_out (lines_sync)
  );

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      pin_level_prev <= 4'h0;
    end else begin
      pin_level_prev <= pin_level_bits;
    end
  end

  // [R13] threshold crossings on pins 1 to 3
  assign cross_event = {1'b0, pin_level_bits[2:0] ^ pin_level_prev[2:0]};

  // [R8] [R23] stuck-low wake timer
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      wake_count <= '0;
      wake_event <= 1'b0;
    end else begin
      wake_event <= 1'b0;
      if (!shutdown || !secondary_config[`MPS_AUTO_WAKE_BIT] || lines_sync != 2'h0) begin
        wake_count <= '0;
      end else if (wake_count == WCW'(WAKE_CYCLES)) begin
        wake_count <= '0;
        wake_event <= 1'b1;
      end else begin
        wake_count <= wake_count + WCW'(1);
      end
    end
  end

  // [R4] [R6] [R7] primary configuration; auto-wake clears the operating field
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      primary_config <= `MPS_RST_PRIMARY_CONFIG;
    end else begin
      if (reg_wr && hit(reg_addr, `MPS_OFS_PRIMARY_CONFIG)) begin
        primary_config <= reg_wdata;
      end
      // [R8] expiry wins over a same-cycle write of the field
      if (wake_event) begin
        primary_config[`MPS_OPMODE_HI:`MPS_OPMODE_LO] <= `MPS_OPMODE_RUN;
      end
    end
  end

  // [R6] configuration registers stay writable in any mode
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      secondary_config           <= `MPS_RST_SECONDARY_CONFIG;
      alert_enable_four_register <= `MPS_RST_ALERT_ENABLE_4;
      pin_io_control             <= `MPS_RST_PIN_IO_CONTROL;
    end else if (reg_wr) begin
      if (hit(reg_addr, `MPS_OFS_SECONDARY_CONFIG)) begin
        secondary_config <= reg_wdata;
      end
      if (hit(reg_addr, `MPS_OFS_ALERT_ENABLE_4)) begin
        alert_enable_four_register <= reg_wdata;
      end
      if (hit(reg_addr, `MPS_OFS_PIN_IO_CONTROL)) begin
        pin_io_control <= reg_wdata;
      end
    end
  end

  // [R9] [R13] enabled wake and crossing events, [R22] fault_alert with no enable, latched until software writes zero
  always_comb begin
    next_alert_latch = 8'h00;
    next_alert_latch[`MPS_AL4_CROSS_HI:`MPS_AL4_CROSS_LO] =
      cross_event[2:0] & alert_enable_four_register[`MPS_AL4_CROSS_HI:`MPS_AL4_CROSS_LO];
    next_alert_latch[`MPS_AL4_WAKE_BIT] = wake_event && alert_enable_four_register[`MPS_AL4_WAKE_BIT];
    next_alert_latch[`MPS_LATCH_EXT_BIT] = fault_alert;
  end

  assign alert_event = |next_alert_latch;

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      alert_latch <= 8'h00;
    end else if (reg_wr && hit(reg_addr, `MPS_OFS_ALERT_LATCH)) begin
      alert_latch <= (alert_latch & reg_wdata) | next_alert_latch;
    end else begin
      alert_latch <= alert_latch | next_alert_latch;
    end
  end

  // [R19] [R21] force bits; [R20] events set the alert bit, winning over a clear
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      alert_pin_force <= `MPS_RST_ALERT_PIN_FORCE;
    end else begin
      if (reg_wr && hit(reg_addr, `MPS_OFS_ALERT_PIN_FORCE)) begin
        alert_pin_force <= {reg_wdata[7:6], 6'h00};
      end
      if (alert_event) begin
        alert_pin_force[`MPS_FORCE_ALERT_BIT] <= 1'b1;
      end
    end
  end

  // [R17] converter status, cleared on read, new updates win
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      conv_status <= 8'h00;
    end else if (status_read) begin
      conv_status <= 8'(result_update);
    end else begin
      conv_status <= conv_status | 8'(result_update);
    end
  end

  // [R15] [R16] data-ready pulse generator for pin 3
  mps_ready_pulse #(
    .SHORT_CYCLES (READY_SHORT),
    .LONG_CYCLES  (READY_LONG)
  ) u_ready (
    .sys_clk       (sys_clk),
    .rst           (logic_reset),
    .mode          (ready_pin_select),
    .new_result    (|result_update),
    .release_latch (status_read),
    .ready_low     (ready_low)
  );

  assign result_available_n = !ready_low;

  // [R14] open-drain drivers: output level is always low, only the enable moves
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      pin_out  <= 4'h0;
      pin_oe_n <= 4'hF;
    end else begin
      pin_out     <= 4'h0;
      // [R11] pins 1 and 2 pull low from the direction control bits
      pin_oe_n[0] <= !pin_io_control[0];
      pin_oe_n[1] <= !pin_io_control[1];
      // [R15] pin 3 carries data-ready when selected
      if (ready_pin_select != `MPS_READY_OFF) begin
        pin_oe_n[2] <= result_available_n;
      end else begin
        pin_oe_n[2] <= !pin_io_control[2];
      end
      // [R18] [R19] [R20] [R21] [R22] pin 4 alert output
      pin_oe_n[3] <= !(alert_pin_force[`MPS_FORCE_ALERT_BIT] || alert_pin_force[`MPS_FORCE_LOW_BIT]
                       || alert_event || pin_io_control[3]);
    end
  end

  // [R5] address straps held while in shutdown
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      bus_addr_sel <= 2'h0;
    end else if (!shutdown) begin
      bus_addr_sel <= {bus_addr_strap_high, bus_addr_strap_low};
    end
  end

  // [R1] [R2] [R4] [R7] power enables
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      bus_logic_enable      <= 1'b0;
      converter_enable      <= 1'b0;
      reference_enable      <= 1'b0;
      regulator_enable      <= 1'b0;
      addr_strap_enable     <= 1'b0;
      shutdown_active       <= 1'b0;
      voltage_converter_sel <= 2'h0;
    end else begin
      // [R5] bus logic stays enabled in shutdown
      bus_logic_enable      <= powered;
      converter_enable      <= powered && !shutdown;
      reference_enable      <= powered && !shutdown;
      regulator_enable      <= powered && !shutdown;
      addr_strap_enable     <= powered && !shutdown;
      shutdown_active       <= shutdown;
      // [R11] conversion selection passed from primary configuration
      voltage_converter_sel <= primary_config[4:3];
    end
  end

  // [R12] [R6] register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `MPS_OFS_PRIMARY_CONFIG:   reg_rdata <= primary_config;
        `MPS_OFS_SECONDARY_CONFIG: reg_rdata <= secondary_config;
        `MPS_OFS_ALERT_ENABLE_4:   reg_rdata <= alert_enable_four_register;
        `MPS_OFS_PIN_IO_CONTROL:   reg_rdata <= pin_io_control;
        `MPS_OFS_PIN_STATUS:       reg_rdata <= {4'h0, pin_level_bits};
        `MPS_OFS_ALERT_LATCH:      reg_rdata <= alert_latch;
        `MPS_OFS_ALERT_PIN_FORCE:  reg_rdata <= alert_pin_force;
        `MPS_OFS_CONV_STATUS:      reg_rdata <= conv_status;
        default:                   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** tb/mps_host_lines.sv ***
// Host side of the serial bus: line levels with external pull-ups
`timescale 1ns/1ns
`default_nettype none
module mps_host_lines (
  // Control from the bench
  input  wire logic              hold_low,
  // Line levels
  output mps_pkg::mps_bus_lines_s bus_lines
);
  // Pull-ups powered off-chip
  // A released line returns to its pull-up level, so a shutdown cannot lose the bus
  assign bus_lines = hold_low ? 2'h0 : 2'h3;
endmodule
`default_nettype wire

// *** tb/mps_tb_top.sv ***
// Self-checking testbench of the power state block
`timescale 1ns/1ns
`default_nettype none
module mps_tb_top;
  localparam int WAKE = 20;
  localparam int RS   = 4;
  localparam int RL   = 8;
  logic                    sys_clk = 1'b0;
  logic                    rst = 1'b1;
  logic [3:0]              reg_addr = 4'h0;
  logic [7:0]              reg_wdata = 8'h00;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  mps_pkg::mps_supply_s    supply = 4'hF;
  logic                    hold_low = 1'b0;
  logic                    strap_lo = 1'b0;
  logic                    strap_hi = 1'b0;
  logic [7:0]              result_update = 8'h00;
  logic                    fault_alert = 1'b0;
  logic [3:0]              pin_cmp = 4'h0;
  mps_pkg::mps_bus_lines_s bus_lines;
  logic [7:0]              reg_rdata;
  logic [3:0]              pin_out;
  logic [3:0]              pin_oe_n;
  logic                    en_bus;
  logic                    en_conv;
  logic                    en_ref;
  logic                    en_reg;
  logic                    strap_en;
  logic [1:0]              addr_sel;
  logic [1:0]              vsel;
  logic                    sd;
  int                      n_fail = 0;
  int                      n_checks = 0;
  int                      cycles = 0;

  always #50 sys_clk = ~sys_clk;

  mps_host_lines u_host (.hold_low(hold_low), .bus_lines(bus_lines));

  mps_top #(.WAKE_CYCLES(WAKE), .READY_SHORT(RS), .READY_LONG(RL), .RESULT_WIDTH(8)) dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply(supply), .bus_lines(bus_lines),
    .bus_addr_strap_low(strap_lo), .bus_addr_strap_high(strap_hi), .result_update(result_update),
    .fault_alert(fault_alert), .pin_cmp(pin_cmp), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .bus_logic_enable(en_bus), .converter_enable(en_conv), .reference_enable(en_ref),
    .regulator_enable(en_reg), .addr_strap_enable(strap_en), .bus_addr_sel(addr_sel),
    .voltage_converter_sel(vsel), .shutdown_active(sd));

  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    cmp(what, exp, reg_rdata);
  endtask

  task automatic t_reset_regs();
    cmp("pin drivers", 8'h0F, {4'h0, pin_oe_n});
    for (int i = 0; i < 9; i++) rdc("register after reset", i[3:0], 8'h00);
  endtask

  task automatic t_shutdown();
    wr(4'h0, 8'h78);
    cyc(3);
    cmp("shutdown flag", 8'h01, {7'h00, sd});
    cmp("analog enables", 8'h00, {4'h0, en_conv, en_ref, en_reg, strap_en});
    cmp("bus logic", 8'h01, {7'h00, en_bus});
    cmp("converter select", 8'h03, {6'h00, vsel});
    strap_lo <= 1'b1;
    strap_hi <= 1'b1;
    cyc(3);
    cmp("address held", 8'h00, {6'h00, addr_sel});
    wr(4'h1, 8'h01);
    rdc("config in shutdown", 4'h1, 8'h01);
    wr(4'h0, 8'h18);
    cyc(3);
    cmp("shutdown left", 8'h00, {7'h00, sd});
    cmp("converter back", 8'h01, {7'h00, en_conv});
    cmp("address follows straps", 8'h03, {6'h00, addr_sel});
    rdc("config kept", 4'h1, 8'h01);
    strap_lo <= 1'b0;
    strap_hi <= 1'b0;
    wr(4'h1, 8'h00);
  endtask

  task automatic t_wake();
    wr(4'h2, 8'h10);
    wr(4'h1, 8'h10);
    wr(4'h0, 8'h60);
    cyc(2);
    hold_low <= 1'b1;
    cyc(WAKE / 2);
    hold_low <= 1'b0;
    cyc(3);
    hold_low <= 1'b1;
    cyc(15);
    cmp("shutdown after restart", 8'h01, {7'h00, sd});
    cmp("alert pin idle", 8'h01, {7'h00, pin_oe_n[3]});
    cyc(15);
    cmp("shutdown after stuck bus", 8'h00, {7'h00, sd});
    rdc("operating field", 4'h0, 8'h00);
    rdc("wake alert", 4'h5, 8'h10);
    cmp("alert pin low", 8'h00, {7'h00, pin_oe_n[3]});
    hold_low <= 1'b0;
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    cyc(3);
    cmp("alert pin released", 8'h01, {7'h00, pin_oe_n[3]});
  endtask

  task automatic pulse_count(input logic [1:0] m, input int exp);
    logic [7:0] lows;
    lows = 8'h00;
    wr(4'h3, {2'h0, m, 4'h0});
    result_update <= 8'h01;
    cyc(1);
    result_update <= 8'h00;
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      lows += {7'h00, !pin_oe_n[2]};
    end
    cmp("ready pulse width", exp[7:0], lows);
  endtask

  task automatic t_ready();
    pulse_count(2'h1, RS);
    pulse_count(2'h2, RL);
    pulse_count(2'h0, 0);
    wr(4'h3, 8'h30);
    result_update <= 8'h04;
    cyc(1);
    result_update <= 8'h00;
    cyc(10);
    cmp("ready latched", 8'h00, {7'h00, pin_oe_n[2]});
    rdc("result flags", 4'h7, 8'h05);
    cyc(2);
    cmp("ready released", 8'h01, {7'h00, pin_oe_n[2]});
    rdc("result flags cleared", 4'h7, 8'h00);
    wr(4'h3, 8'h00);
  endtask

  task automatic t_pins();
    wr(4'h3, 8'h03);
    cyc(1);
    cmp("pin pulls", 8'h0C, {4'h0, pin_oe_n});
    wr(4'h3, 8'h00);
    pin_cmp <= 4'hA;
    cyc(4);
    rdc("pin levels", 4'h4, 8'h0A);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    wr(4'h2, 8'h02);
    pin_cmp <= 4'h8;
    cyc(6);
    cmp("disabled crossing", 8'h01, {7'h00, pin_oe_n[3]});
    pin_cmp <= 4'h9;
    cyc(6);
    cmp("enabled crossing", 8'h00, {7'h00, pin_oe_n[3]});
    rdc("force after event", 4'h6, 8'h80);
    wr(4'h6, 8'h00);
    wr(4'h5, 8'h00);
    cyc(2);
    cmp("alert cleared", 8'h01, {7'h00, pin_oe_n[3]});
    wr(4'h6, 8'h40);
    cyc(2);
    cmp("force low", 8'h00, {7'h00, pin_oe_n[3]});
    wr(4'h6, 8'h00);
    cyc(2);
    cmp("force released", 8'h01, {7'h00, pin_oe_n[3]});
    fault_alert <= 1'b1;
    cyc(1);
    fault_alert <= 1'b0;
    cyc(2);
    cmp("fault alert", 8'h00, {7'h00, pin_oe_n[3]});
    wr(4'h2, 8'h00);
  endtask

  task automatic t_power();
    wr(4'h1, 8'h10);
    supply <= 4'h3;
    cyc(4);
    cmp("converter without supply", 8'h00, {7'h00, en_conv});
    supply <= 4'h7;
    cyc(4);
    cmp("converter on internal", 8'h01, {7'h00, en_conv});
    rdc("config retained", 4'h1, 8'h10);
    supply <= 4'h0;
    cyc(3);
    supply <= 4'h7;
    cyc(6);
    rdc("config after logic reset", 4'h1, 8'h00);
    cmp("bus logic back", 8'h01, {7'h00, en_bus});
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(3);
    t_reset_regs();
    t_shutdown();
    t_wake();
    t_ready();
    t_pins();
    t_power();
    final_report();
  end
endmodule
`default_nettype wire

// *** tb/mps_top_asserts.sv ***
// Concurrent checks on the power state block ports
`timescale 1ns/1ns
`default_nettype none
module mps_top_asserts #(
  parameter int READY_SHORT = 160,
  parameter int READY_LONG  = 1280
) (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst,
  // Register port
  input wire logic [3:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  // Supplies, pins and power state
  input wire mps_pkg::mps_supply_s supply,
  input wire logic [3:0]           pin_out,
  input wire logic [3:0]           pin_oe_n,
  input wire logic                 bus_logic_enable,
  input wire logic                 converter_enable,
  input wire logic                 reference_enable,
  input wire logic                 regulator_enable,
  input wire logic [1:0]           bus_addr_sel,
  input wire logic                 shutdown_active
);
  logic [1:0]  rdy_mode;
  int unsigned low_len;

  // Ready mode as last written, for the pulse width check
  always_ff @(posedge sys_clk) begin
    if (rst) rdy_mode <= 2'h0;
    else if (reg_wr && reg_addr == 4'h3) rdy_mode <= reg_wdata[5:4];
  end

  // Length of the current low stretch on pin 3
  always_ff @(posedge sys_clk) begin
    if (rst || pin_oe_n[2]) low_len <= 0;
    else low_len <= low_len + 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_enter_sd;
    reg_wr && reg_addr == 4'h0 && reg_wdata[6:5] == 2'h3;
  endsequence
  sequence s_powered;
    (supply.main_above_uvlo || supply.internal_above_uvlo) && (supply.main_above_reset || supply.internal_above_reset);
  endsequence
  sequence s_supply_lost;
    !supply.main_above_uvlo && !supply.internal_above_uvlo;
  endsequence

  a_open_drain_only:
    assert property (pin_out == 4'h0) else $error("pin output driven high");
  a_enter_shutdown:
    assert property (s_enter_sd |-> ##2 shutdown_active) else $error("shutdown not entered");
  a_analog_off:
    assert property (shutdown_active |-> !converter_enable && !reference_enable && !regulator_enable)
      else $error("analog left on in shutdown");
  a_enable_on_supply:
    assert property (s_powered [*6] |-> bus_logic_enable) else $error("bus logic not enabled");
  a_adc_off_uvlo:
    assert property (s_supply_lost [*2] |=> !converter_enable) else $error("converter on without supply");
  a_addr_held:
    assert property (shutdown_active && $past(shutdown_active) |-> $stable(bus_addr_sel))
      else $error("address changed in shutdown");
  a_pin_pull_write:
    assert property (reg_wr && reg_addr == 4'h3 |-> ##2 pin_oe_n[1:0] == ~$past(reg_wdata[1:0], 2))
      else $error("pin pull does not follow write");
  a_alert_force_low:
    assert property (reg_wr && reg_addr == 4'h6 && (reg_wdata[7] || reg_wdata[6]) |-> ##2 !pin_oe_n[3])
      else $error("alert pin not forced low");
  a_ready_width:
    assert property ($rose(pin_oe_n[2]) && rdy_mode inside {2'h1, 2'h2}
      |-> low_len == (rdy_mode == 2'h1 ? READY_SHORT : READY_LONG)) else $error("ready pulse width wrong");
endmodule

bind mps_top mps_top_asserts #(
  .READY_SHORT(READY_SHORT),
  .READY_LONG (READY_LONG)
) u_chk (
  .sys_clk         (sys_clk),
  .rst             (rst),
  .reg_addr        (reg_addr),
  .reg_wdata       (reg_wdata),
  .reg_wr          (reg_wr),
  .supply          (supply),
  .pin_out         (pin_out),
  .pin_oe_n        (pin_oe_n),
  .bus_logic_enable(bus_logic_enable),
  .converter_enable(converter_enable),
  .reference_enable(reference_enable),
  .regulator_enable(regulator_enable),
  .bus_addr_sel    (bus_addr_sel),
  .shutdown_active (shutdown_active)
);
`default_nettype wire
